// File: logic/gpm_consts.svh
// Constants of the pin 8 to 10 output multiplexer: offsets, field positions, reset values.
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH

// ==========================================
// Register byte offsets (address bits 11:0)
`define GPM_OFS_CTRL       12'h000
`define GPM_OFS_MODE       12'h004
`define GPM_OFS_DATA       12'h008
`define GPM_OFS_STATUS     12'h00c
`define GPM_OFS_ADC        12'h010

// ==========================================
// Control register fields
`define GPM_CTRL_OE_LSB    0
`define GPM_CTRL_DAC       3
`define GPM_CTRL_INBUF     4
`define GPM_CTRL_PLUS      5
`define GPM_CTRL_MINUS     6
`define GPM_CTRL_W         7

// ==========================================
// Mode register fields, three bits per pin
`define GPM_MODE_P8_LSB    0
`define GPM_MODE_P9_LSB    3
`define GPM_MODE_P10_LSB   6
`define GPM_MODE_W         9

// ==========================================
// Status and converter fields
`define GPM_STAT_OE_LSB    3
`define GPM_ADC_CH_W       5
`define GPM_ADC_START      8

// ==========================================
// Reset values
`define GPM_RST_CTRL       7'h00
`define GPM_RST_MODE       9'h000
`define GPM_RST_DATA       3'h0
`define GPM_RST_ADC_CH     5'h00

`endif

// File: logic/gpm_gpio_mux.sv
// Output multiplexer of general purpose pins 8, 9 and 10 with its APB registers.
//
// Overview of operation
// - Pin 8 mode selects data, PWM, comparator
// - Sink converter enable forces pin 8 undriven
// - Pin 8 reads only with input enable set
// - Pin 9 mode selects data, interrupt, PWM, loop
// - Plus route forces pin 9 undriven outside identification read
// - Identification read takes over pin 9
// - Pin 9 output feeds bridge PWM one
// - Pin 10 mode selects data, interrupt, PWMs
// - Minus route forces pin 10 undriven outside identification read
// - Identification read takes over pin 10
// - Pin 10 output feeds bridge PWM two
// - Pins 9, 10 always converter selectable
// - Pins 9, 10 levels always readable
// - Disabled output leaves pin floating, except pins 9, 10 in identification read
`timescale 1ns/1ps
`include "gpm_consts.svh"
module gpm_gpio_mux (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              arst_n,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Internal sources.
	input  wire gpm_pkg::gpm_src_t src,
	// Identification read takeover of pins 9 and 10.
	input  wire logic              idReadActive,
	input  wire logic [1:0]        idPinOut,
	input  wire logic [1:0]        idPinOeN,
	// Pads of pins 8, 9, 10.
	input  wire logic [2:0]        pinIn,
	output gpm_pkg::gpm_pad_t      pad,
	// Analog controls and bridge feeds.
	output gpm_pkg::gpm_ana_t      ana,
	output logic                   bridgeExtPwmOne,
	output logic                   bridgeExtPwmTwo,
	// Converter channel request.
	output logic [4:0]             adcChannelSelect,
	output logic                   adcStart
);
	import gpm_pkg::*;

	// ==========================================
	// Declarations
	logic [`GPM_CTRL_W-1:0]   ctrl_ff;      // Enables and analog routing.
	logic [`GPM_MODE_W-1:0]   mode_ff;      // Three mode fields.
	logic [2:0]               data_ff;      // Serial output data.
	logic [4:0]               adcChan_ff;   // Converter channel field.
	logic                     adcStart_ff;  // Conversion start pulse.
	logic [31:0]              prdata_ff;    // Read data, loaded in setup.
	gpm_pad_t                 pad_ff;       // Registered pad drive.
	logic [2:0]               muxOut;       // Selected pin values.
	logic [2:0]               muxOeN;       // Selected enables, low drives.
	logic [2:0]               override;     // Analog use per pin.
	logic [2:0]               nxt_out;      // Pad value after takeover.
	logic [2:0]               nxt_oeN;      // Pad enable after takeover.
	logic                     setupPhase;   // APB setup cycle.
	logic                     accessPhase;  // APB access cycle.
	logic                     mapped;       // Address hits a register.
	logic                     wrEn;         // Write takes effect.
	logic [11:0]              ofs;          // Decoded address bits.
	logic [31:0]              nxt_prdata;   // Read data of the address.
	logic [2:0]               pinLevel;     // Readable pin levels.

	assign ofs         = paddr[11:0];
	assign setupPhase  = psel & ~penable;
	assign accessPhase = psel & penable;

	// ==========================================
	// Address decode
	// Upper address bits must be zero; anything else is an error.
	always_comb begin
		case (ofs)
			`GPM_OFS_CTRL, `GPM_OFS_MODE, `GPM_OFS_DATA,
			`GPM_OFS_STATUS, `GPM_OFS_ADC: mapped = (paddr[31:12] == 20'h00000);
			default: mapped = 1'b0;
		endcase
	end

	// The slave never waits; unmapped accesses answer with an error.
	assign pready  = 1'b1;
	assign pslverr = accessPhase & ~mapped;
	assign wrEn    = accessPhase & pwrite & mapped;

	// ==========================================
	// Control registers
	// Writes land only at the completing access edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= `GPM_RST_CTRL;
		end else if (wrEn && ofs == `GPM_OFS_CTRL) begin
			ctrl_ff <= pwdata[`GPM_CTRL_W-1:0];
		end
	end

	// Mode fields of the three pins.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= `GPM_RST_MODE;
		end else if (wrEn && ofs == `GPM_OFS_MODE) begin
			mode_ff <= pwdata[`GPM_MODE_W-1:0];
		end
	end

	// Serial output data bits.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_ff <= `GPM_RST_DATA;
		end else if (wrEn && ofs == `GPM_OFS_DATA) begin
			data_ff <= pwdata[2:0];
		end
	end

	// Converter channel; pins 9 and 10 stay selectable in every pin mode.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adcChan_ff  <= `GPM_RST_ADC_CH;
			adcStart_ff <= 1'b0;
		end else begin
			adcStart_ff <= 1'b0;
			if (wrEn && ofs == `GPM_OFS_ADC) begin
				adcChan_ff  <= pwdata[`GPM_ADC_CH_W-1:0];
				adcStart_ff <= pwdata[`GPM_ADC_START];
			end
		end
	end

	assign adcChannelSelect = adcChan_ff;
	assign adcStart         = adcStart_ff;

	// ==========================================
	// Analog overrides
	// Each analog use takes its pin away from the digital output.
	assign override[0] = ctrl_ff[`GPM_CTRL_DAC];
	assign override[1] = ctrl_ff[`GPM_CTRL_PLUS];
	assign override[2] = ctrl_ff[`GPM_CTRL_MINUS];

	assign ana.sinkDacEnable   = ctrl_ff[`GPM_CTRL_DAC];
	assign ana.pin8InputEnable = ctrl_ff[`GPM_CTRL_INBUF];
	assign ana.ampPlusRoute    = ctrl_ff[`GPM_CTRL_PLUS];
	assign ana.ampMinusRoute   = ctrl_ff[`GPM_CTRL_MINUS];

	// ==========================================
	// Pin selectors
	// Pin 8: PWM one, PWM three, comparator two.
	gpm_pin_mux u_pin8 (
		.serialBit      (data_ff[0]),
		.srcOne         (src.pwmOne),
		.srcTwo         (src.pwmThree),
		.srcThree       (src.cmpTwo),
		.mode           (gpm_mode_t'(mode_ff[`GPM_MODE_P8_LSB +: 3])),
		.outEnable      (ctrl_ff[`GPM_CTRL_OE_LSB]),
		.analogOverride (override[0]),
		.pinOut         (muxOut[0]),
		.pinOeN         (muxOeN[0])
	);

	// Pin 9: interrupt line, PWM two, regulator loop three.
	gpm_pin_mux u_pin9 (
		.serialBit      (data_ff[1]),
		.srcOne         (src.intLine),
		.srcTwo         (src.pwmTwo),
		.srcThree       (src.loopThree),
		.mode           (gpm_mode_t'(mode_ff[`GPM_MODE_P9_LSB +: 3])),
		.outEnable      (ctrl_ff[`GPM_CTRL_OE_LSB + 1]),
		.analogOverride (override[1]),
		.pinOut         (muxOut[1]),
		.pinOeN         (muxOeN[1])
	);

	// Pin 10: interrupt line, PWM two, PWM three.
	gpm_pin_mux u_pin10 (
		.serialBit      (data_ff[2]),
		.srcOne         (src.intLine),
		.srcTwo         (src.pwmTwo),
		.srcThree       (src.pwmThree),
		.mode           (gpm_mode_t'(mode_ff[`GPM_MODE_P10_LSB +: 3])),
		.outEnable      (ctrl_ff[`GPM_CTRL_OE_LSB + 2]),
		.analogOverride (override[2]),
		.pinOut         (muxOut[2]),
		.pinOeN         (muxOeN[2])
	);

	// ==========================================
	// Identification takeover
	// While the identification read runs, the system owns pins 9 and 10.
	always_comb begin
		nxt_out = muxOut;
		nxt_oeN = muxOeN;
		if (idReadActive) begin
			nxt_out[2:1] = idPinOut;
			nxt_oeN[2:1] = idPinOeN;
		end
	end

	// Pad drive is registered so the pins never glitch on mode changes.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_ff.out <= 3'h0;
			pad_ff.oeN <= 3'h7;
		end else begin
			pad_ff.out <= nxt_out;
			pad_ff.oeN <= nxt_oeN;
		end
	end

	assign pad = pad_ff;

	// Bridges see the registered pad values of pins 9 and 10, not the pin levels, so stray pin pulses never reach them.
	assign bridgeExtPwmOne = pad_ff.out[1];
	assign bridgeExtPwmTwo = pad_ff.out[2];

	// ==========================================
	// Read path
	// Pin 8 reads zero until its input buffer is enabled.
	assign pinLevel[0]   = pinIn[0] & ctrl_ff[`GPM_CTRL_INBUF];
	assign pinLevel[2:1] = pinIn[2:1];

	// Read data of the addressed register.
	always_comb begin
		nxt_prdata = 32'h00000000;
		case (ofs)
			`GPM_OFS_CTRL:   nxt_prdata[`GPM_CTRL_W-1:0] = ctrl_ff;
			`GPM_OFS_MODE:   nxt_prdata[`GPM_MODE_W-1:0] = mode_ff;
			`GPM_OFS_DATA:   nxt_prdata[2:0] = data_ff;
			`GPM_OFS_STATUS: begin
				nxt_prdata[2:0] = pinLevel;
				nxt_prdata[`GPM_STAT_OE_LSB +: 3] = ~pad_ff.oeN;
			end
			`GPM_OFS_ADC:    nxt_prdata[4:0] = adcChan_ff;
			default:         nxt_prdata = 32'h00000000;
		endcase
		if (!mapped) begin
			nxt_prdata = 32'h00000000;
		end
	end

	// Read data is captured in the setup cycle and held through access.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Completed APB write to the converter register with the start bit.
	sequence s_adc_go;
		psel && penable && pwrite && paddr == 32'h00000010 && pwdata[8];
	endsequence

	property p_adc_start;
		s_adc_go |=> adcStart ##1 !adcStart;
	endproperty
	a_adc_start: assert property (p_adc_start) else $error("conversion start not a pulse");

	property p_dac_oe;
		ctrl_ff[3] |=> pad.oeN[0];
	endproperty
	a_dac_oe: assert property (p_dac_oe) else $error("pin 8 driven with sink on");

	property p_plus_oe;
		ctrl_ff[5] && !idReadActive |=> pad.oeN[1];
	endproperty
	a_plus_oe: assert property (p_plus_oe) else $error("pin 9 driven with plus route");

	property p_minus_oe;
		ctrl_ff[6] && !idReadActive |=> pad.oeN[2];
	endproperty
	a_minus_oe: assert property (p_minus_oe) else $error("pin 10 driven with minus route");

	property p_hiz8;
		!ctrl_ff[3] && !ctrl_ff[0] |=> pad.oeN[0];
	endproperty
	a_hiz8: assert property (p_hiz8) else $error("pin 8 driven while disabled");

	property p_p8_pwm1;
		!ctrl_ff[3] && ctrl_ff[0] && mode_ff[2:0] == 3'h1
			|=> !pad.oeN[0] && pad.out[0] == $past(src.pwmOne);
	endproperty
	a_p8_pwm1: assert property (p_p8_pwm1) else $error("pin 8 not carrying PWM one");

	property p_p9_bridge;
		!idReadActive && !ctrl_ff[5] && ctrl_ff[1] && mode_ff[5:3] == 3'h2
			|=> bridgeExtPwmOne == $past(src.pwmTwo);
	endproperty
	a_p9_bridge: assert property (p_p9_bridge) else $error("bridge one feed wrong");

	property p_p10_inv3;
		!idReadActive && ctrl_ff[2] && mode_ff[8:6] == 3'h7
			|=> pad.out[2] == !$past(src.pwmThree) && bridgeExtPwmTwo == pad.out[2];
	endproperty
	a_p10_inv3: assert property (p_p10_inv3) else $error("pin 10 code 7 wrong");

	property p_low8;
		mode_ff[2:0] == 3'h6 |=> !pad.out[0];
	endproperty
	a_low8: assert property (p_low8) else $error("code 6 not low");

	property p_id9;
		idReadActive |=> pad.out[1] == $past(idPinOut[0]) && pad.oeN[1] == $past(idPinOeN[0]);
	endproperty
	a_id9: assert property (p_id9) else $error("pin 9 not taken over");

	property p_rd8;
		setupPhase && !pwrite && paddr == 32'h0000000c && !ctrl_ff[4] |=> !prdata[0];
	endproperty
	a_rd8: assert property (p_rd8) else $error("pin 8 read without buffer");

	property p_rd9;
		setupPhase && !pwrite && paddr == 32'h0000000c |=> prdata[1] == $past(pinIn[1]);
	endproperty
	a_rd9: assert property (p_rd9) else $error("pin 9 level not readable");

endmodule

// File: logic/gpm_pin_mux.sv
// Output function selector of one general purpose pin.
`timescale 1ns/1ps
module gpm_pin_mux (
	// Sources.
	input  wire logic              serialBit,
	input  wire logic              srcOne,
	input  wire logic              srcTwo,
	input  wire logic              srcThree,
	// Controls.
	input  wire gpm_pkg::gpm_mode_t mode,
	input  wire logic              outEnable,
	input  wire logic              analogOverride,
	// Result.
	output logic                   pinOut,
	output logic                   pinOeN
);
	import gpm_pkg::*;

	// ==========================================
	// Function select
	// Codes 1xx give the inverted sources; 110 has no function and drives low.
	always_comb begin
		case (mode)
			GPM_MODE_DATA: pinOut = serialBit;
			GPM_MODE_SRC1: pinOut = srcOne;
			GPM_MODE_SRC2: pinOut = srcTwo;
			GPM_MODE_SRC3: pinOut = srcThree;
			GPM_MODE_INV1: pinOut = ~srcOne;
			GPM_MODE_INV2: pinOut = ~srcTwo;
			GPM_MODE_INV3: pinOut = ~srcThree;
			GPM_MODE_LOW:  pinOut = 1'b0;
			default:       pinOut = 1'b0;
		endcase
	end

	// Analog use forces the enable off; a cleared enable leaves the pin floating.
	assign pinOeN = analogOverride | ~outEnable;

endmodule

// File: logic/gpm_pkg.sv
// Types shared by the pin 8 to 10 output multiplexer.
package gpm_pkg;

	// Output function codes of one pin.
	typedef enum logic [2:0] {
		GPM_MODE_DATA = 3'h0,
		GPM_MODE_SRC1 = 3'h1,
		GPM_MODE_SRC2 = 3'h2,
		GPM_MODE_SRC3 = 3'h3,
		GPM_MODE_INV1 = 3'h4,
		GPM_MODE_INV2 = 3'h5,
		GPM_MODE_LOW  = 3'h6,
		GPM_MODE_INV3 = 3'h7
	} gpm_mode_t;

	// Internal signal sources that the pins may carry.
	typedef struct packed {
		logic pwmOne;
		logic pwmTwo;
		logic pwmThree;
		logic cmpTwo;
		logic intLine;
		logic loopThree;
	} gpm_src_t;

	// Pad drive of pins 8, 9, 10 (index 0, 1, 2).
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oeN;
	} gpm_pad_t;

	// Analog routing controls handed to the analog blocks.
	typedef struct packed {
		logic sinkDacEnable;
		logic pin8InputEnable;
		logic ampPlusRoute;
		logic ampMinusRoute;
	} gpm_ana_t;

endpackage

// File: testbench/gpm_board_model.sv
// Board circuitry model that resolves the levels on pins 8, 9 and 10.
`timescale 1ns/1ps
module gpm_board_model (
	// Pad drive from the device.
	input  wire gpm_pkg::gpm_pad_t pad,
	// Level the board puts on a pin that the device leaves floating.
	input  wire logic [2:0]        extLevel,
	// Resolved pin levels seen by the input buffers.
	output logic [2:0]             pinIn
);
	import gpm_pkg::*;

	// ==========================================
	// Pin resolution
	// A driven pin shows the device level; a floating pin shows the board level.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pinIn[i] = pad.oeN[i] ? extLevel[i] : pad.out[i];
		end
	end
endmodule

// File: testbench/gpm_gpio_mux_tb.sv
// Self-checking bench of the pin 8 to 10 output multiplexer.
`timescale 1ns/1ps
`include "gpm_consts.svh"
module gpm_gpio_mux_tb;
	import gpm_pkg::*;

	// ==========================================
	// Signals
	logic        clk = 1'b0;       // Core clock.
	logic        arst_n;           // Reset, active low.
	logic        psel;             // APB select.
	logic        penable;          // APB enable.
	logic        pwrite;           // APB direction.
	logic [31:0] paddr;            // APB address.
	logic [31:0] pwdata;           // APB write data.
	logic [31:0] prdata;           // APB read data.
	logic        pready;           // APB ready.
	logic        pslverr;          // APB error.
	gpm_src_t    src;              // Internal sources.
	logic        idReadActive;     // Identification read owns pins 9 and 10.
	logic [1:0]  idPinOut;         // System drive level.
	logic [1:0]  idPinOeN;         // System drive enable, low drives.
	logic [2:0]  pinIn;            // Pin levels.
	logic [2:0]  extLevel;         // Board level on floating pins.
	gpm_pad_t    pad;              // Pad drive.
	gpm_ana_t    ana;              // Analog controls.
	logic        bridgeExtPwmOne;  // Bridge feed one.
	logic        bridgeExtPwmTwo;  // Bridge feed two.
	logic [4:0]  adcChannelSelect; // Converter channel.
	logic        adcStart;         // Converter start pulse.
	logic [31:0] rd;               // Last read data.
	logic        err;              // Last error flag.
	int          mismatches = 0;   // Failed comparisons.
	int          nCompared = 0;    // All comparisons.
	int          nStart = 0;       // Start pulses seen.
	int          seed = 60142;     // Fixed random seed.

	// Clock of 25 ns period.
	always #12.5 clk = ~clk;

	// Counts converter start pulses, one per high cycle.
	always @(posedge clk) begin
		if (adcStart === 1'b1) begin
			nStart <= nStart + 1;
		end
	end

	// ==========================================
	// Instances
	gpm_gpio_mux gpm_gpio_mux_inst (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src(src), .idReadActive(idReadActive), .idPinOut(idPinOut),
		.idPinOeN(idPinOeN), .pinIn(pinIn), .pad(pad), .ana(ana),
		.bridgeExtPwmOne(bridgeExtPwmOne), .bridgeExtPwmTwo(bridgeExtPwmTwo),
		.adcChannelSelect(adcChannelSelect), .adcStart(adcStart));
	gpm_board_model gpm_board_model_inst (.pad(pad), .extLevel(extLevel), .pinIn(pinIn));

	// ==========================================
	// Bench tasks
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compares one value and reports a difference.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	// One APB transfer, entered just after a rising edge; waits for pready a bounded time.
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			mismatches++;
			test_done();
		end
		@(posedge clk);
	endtask

	// Expected pad drive from controls, modes, data, sources and the identification read.
	function automatic gpm_pad_t expPad(input logic [6:0] c, input logic [8:0] m,
		input logic [2:0] d, input gpm_src_t s, input logic ida, input logic [3:0] idv);
		gpm_pad_t   p;
		logic [2:0] one;
		logic [2:0] two;
		logic [2:0] three;
		logic [2:0] ov;
		one = {s.intLine, s.intLine, s.pwmOne};
		two = {s.pwmTwo, s.pwmTwo, s.pwmThree};
		three = {s.pwmThree, s.loopThree, s.cmpTwo};
		ov = {c[6], c[5], c[3]};
		for (int i = 0; i < 3; i++) begin
			case (m[3*i +: 3])
				3'h0: p.out[i] = d[i];
				3'h1: p.out[i] = one[i];
				3'h2: p.out[i] = two[i];
				3'h3: p.out[i] = three[i];
				3'h4: p.out[i] = ~one[i];
				3'h5: p.out[i] = ~two[i];
				3'h6: p.out[i] = 1'b0;
				default: p.out[i] = ~three[i];
			endcase
			p.oeN[i] = ~(c[i] & ~ov[i]);
		end
		// The identification read owns pins 9 and 10.
		if (ida) begin
			p.out[2:1] = idv[3:2];
			p.oeN[2:1] = idv[1:0];
		end
		return p;
	endfunction

	// Programs one configuration, applies inputs and checks pads, feeds and readback.
	task automatic run(input logic [6:0] c, input logic [8:0] m, input logic [2:0] d,
		input logic [5:0] s, input logic ida, input logic [3:0] idv, input logic [2:0] ext);
		gpm_pad_t   e;
		logic [2:0] lvl;
		apb(1'b1, 32'(`GPM_OFS_CTRL), {25'h0, c});
		apb(1'b1, 32'(`GPM_OFS_MODE), {23'h0, m});
		apb(1'b1, 32'(`GPM_OFS_DATA), {29'h0, d});
		src <= gpm_src_t'(s);
		idReadActive <= ida;
		{idPinOut, idPinOeN} <= idv;
		extLevel <= ext;
		@(posedge clk);
		@(posedge clk);
		e = expPad(c, m, d, gpm_src_t'(s), ida, idv);
		lvl = (e.oeN & ext) | (~e.oeN & e.out);
		check("oeN", 32'(e.oeN), 32'(pad.oeN));
		check("out", 32'(e.out & ~e.oeN), 32'(pad.out & ~e.oeN));
		// The feeds carry the selected value even while the pin is not driven.
		check("bridge", 32'(e.out[2:1]), 32'({bridgeExtPwmTwo, bridgeExtPwmOne}));
		check("ana", 32'({c[3], c[4], c[5], c[6]}), 32'(ana));
		apb(1'b0, 32'(`GPM_OFS_STATUS), 32'h0);
		check("status", {26'h0, ~e.oeN, lvl[2:1], lvl[0] & c[4]}, rd);
		apb(1'b0, 32'(`GPM_OFS_MODE), 32'h0);
		check("mode", {23'h0, m}, rd);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		logic [4:0] ch;
		{psel, penable, pwrite} = 3'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		src = '0;
		idReadActive = 1'b0;
		idPinOut = 2'h0;
		idPinOeN = 2'h3;
		extLevel = 3'h0;
		arst_n = 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		check("reset oeN", 32'h7, 32'(pad.oeN));
		// Reset values of every register and the unmapped word after them.
		for (int a = 0; a <= 20; a += 4) begin
			apb(1'b0, 32'(a), 32'h0);
			check("reset read", 32'h0, rd);
			check("pslverr", 32'(a == 20), 32'(err));
		end
		// Unmapped and read-only writes leave the registers alone.
		apb(1'b1, 32'h0000_1000, 32'h7f);
		check("pslverr", 32'h1, 32'(err));
		apb(1'b1, 32'(`GPM_OFS_STATUS), 32'h3f);
		apb(1'b0, 32'(`GPM_OFS_CTRL), 32'h0);
		check("ctrl", 32'h0, rd);
		// Every mode code on all three pins at once.
		for (int k = 0; k < 16; k++) begin
			run(7'h07, {3{k[2:0]}}, 3'($random(seed)), 6'($random(seed)), 1'b0, 4'h3,
				3'($random(seed)));
		end
		// Overrides together with the identification read.
		run(7'h7f, 9'h1ff, 3'h7, 6'h3f, 1'b1, 4'hc, 3'h5);
		// Random configurations.
		for (int k = 0; k < 60; k++) begin
			run(7'($random(seed)), 9'($random(seed)), 3'($random(seed)), 6'($random(seed)),
				($random(seed) & 3) == 0, 4'($random(seed)), 3'($random(seed)));
		end
		// Converter channel select and start pulse, top channel first.
		for (int k = 0; k < 4; k++) begin
			ch = (k == 0) ? 5'h1f : 5'($random(seed));
			apb(1'b1, 32'(`GPM_OFS_ADC), {23'h0, 1'b1, 3'h0, ch});
			check("channel", 32'(ch), 32'(adcChannelSelect));
			apb(1'b0, 32'(`GPM_OFS_ADC), 32'h0);
			check("adc read", 32'(ch), rd);
		end
		apb(1'b1, 32'(`GPM_OFS_ADC), 32'h0);
		check("starts", 32'h4, 32'(nStart));
		test_done();
	end
endmodule
